// ==== design/port_share_pkg.sv ====
// Package for the memory port share and board strobe block.
// Assumes one 125 MHz system clock; pins synchronised inside the block.
package port_share_pkg;
   // ****************************************************
   // Register map (plain register port)
   // ****************************************************
   localparam int        ADDR_W              = 4;
   localparam logic [3:0] OFS_BOARD_CTRL     = 4'h0;
   localparam logic [3:0] OFS_SERIAL_MEM     = 4'h1;
   localparam logic [3:0] OFS_DEVICE_CONFIG  = 4'h2;
   localparam logic [3:0] OFS_CHIP_CTRL      = 4'h3;
   localparam logic [3:0] OFS_PORT_CTRL      = 4'h4;
   // ****************************************************
   // Field positions
   // ****************************************************
   // board_control_reg
   localparam int        BIT_BOARD_READ      = 0;
   localparam int        BIT_BOARD_STROBE    = 1;
   localparam int        BRD_DATA_LO         = 2;
   localparam int        BRD_DATA_HI         = 7;
   // serial_mem_ctrl_reg
   localparam int        BIT_SERIAL_SEL      = 0;
   localparam int        BIT_GRANT_LEVEL     = 7;
   // device_config_reg
   localparam int        BIT_SINGLE_USER     = 0;
   // chip control
   localparam int        BIT_CHIP_RESET      = 0;
   // port control: software wants the port / a cycle is running
   localparam int        BIT_PORT_WANT       = 0;
   localparam int        BIT_CYCLE_BUSY      = 1;
   localparam int        BIT_READ_CYCLE      = 2;
   localparam int        BIT_PORT_OWNED      = 3;
   // ****************************************************
   // Reset values
   // ****************************************************
   localparam logic [7:0] RST_BYTE           = 8'h00;
   localparam logic [1:0] SYNC_RST           = 2'h3;
endpackage

// ==== design/memory_port_share.sv ====
// Memory port arbitration and board strobe logic.
// Assumes the grant pin and bus reset come from outside the clock domain,
// and that the external arbitrator runs off the same reference clock.
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/1ps

module memory_port_share
   import port_share_pkg::*;
(
   input  wire logic              sys_clk_i,
   input  wire logic              resetn_i,
   input  wire logic              clk_en_i,
   // Register port
   input  wire logic [ADDR_W-1:0] reg_addr_i,
   input  wire logic [7:0]        reg_wdata_i,
   input  wire logic              reg_wr_i,
   input  wire logic              reg_rd_i,
   output logic      [7:0]        reg_rdata_o,
   // Pins
   input  wire logic              host_bus_reset_n_i,
   input  wire logic              port_grant_n_i,
   input  wire logic              single_user_strap_i,
   input  wire logic [4:0]        mem_data_upper_i,
   input  wire logic              mem_data_parity_i,
   output logic                   port_request_n_o,
   output logic                   port_request_n_oe_o,
   output logic                   port_drive_en_o,
   output logic                   board_out_en_n_o,
   output logic                   board_out_en_n_oe_o,
   output logic                   board_write_strobe_o,
   output logic                   board_write_strobe_oe_o,
   // Sequencer / host side
   output logic                   port_stall_o
);
   // ****************************************************
   // Pin synchronisers
   // ****************************************************
   logic [1:0] grant_sync_q;
   logic [1:0] busrst_sync_q;
   logic [5:0] md_sync1_q;
   logic [5:0] md_sync2_q;
   logic [1:0] strap_sync_q;

   // Grant idles high through its pull-up; first stage read only by second
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         grant_sync_q  <= SYNC_RST;
         busrst_sync_q <= 2'h0;
         md_sync1_q    <= 6'h00;
         md_sync2_q    <= 6'h00;
         strap_sync_q  <= 2'h0;
      end else if (clk_en_i) begin
         grant_sync_q  <= {grant_sync_q[0], port_grant_n_i};
         busrst_sync_q <= {busrst_sync_q[0], host_bus_reset_n_i};
         md_sync1_q    <= {mem_data_upper_i, mem_data_parity_i};
         md_sync2_q    <= md_sync1_q;
         strap_sync_q  <= {strap_sync_q[0], single_user_strap_i};
      end
   end

   wire grant_s   = ~grant_sync_q[1];
   wire bus_rst_s = ~busrst_sync_q[1];

   // ****************************************************
   // Software registers
   // ****************************************************
   logic       board_read_select_q;
   logic       board_strobe_bit_q;
   logic       serial_mem_select_q;
   logic       chip_reset_bit_q;
   logic       port_want_q;
   logic       read_cycle_q;
   logic       cycle_busy_q;
   logic       single_user_q;
   logic       strap_taken_q;

   wire wr_board = reg_wr_i && (reg_addr_i == OFS_BOARD_CTRL);
   wire wr_ser   = reg_wr_i && (reg_addr_i == OFS_SERIAL_MEM);
   wire wr_chip  = reg_wr_i && (reg_addr_i == OFS_CHIP_CTRL);
   wire wr_port  = reg_wr_i && (reg_addr_i == OFS_PORT_CTRL);

   // Bus reset clears control bits as well as floating pins
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         board_read_select_q <= 1'b0;
         board_strobe_bit_q  <= 1'b0;
         serial_mem_select_q <= 1'b0;
         chip_reset_bit_q    <= 1'b0;
         port_want_q         <= 1'b0;
         read_cycle_q        <= 1'b0;
         cycle_busy_q        <= 1'b0;
      end else if (clk_en_i) begin
         if (bus_rst_s) begin
            board_read_select_q <= 1'b0;
            board_strobe_bit_q  <= 1'b0;
            serial_mem_select_q <= 1'b0;
            chip_reset_bit_q    <= 1'b0;
            port_want_q         <= 1'b0;
            read_cycle_q        <= 1'b0;
            cycle_busy_q        <= 1'b0;
         end else begin
            if (wr_board) begin
               board_read_select_q <= reg_wdata_i[BIT_BOARD_READ];
               board_strobe_bit_q  <= reg_wdata_i[BIT_BOARD_STROBE];
            end
            if (wr_ser)
               serial_mem_select_q <= reg_wdata_i[BIT_SERIAL_SEL];
            if (wr_chip)
               chip_reset_bit_q <= reg_wdata_i[BIT_CHIP_RESET];
            if (wr_port) begin
               port_want_q  <= reg_wdata_i[BIT_PORT_WANT];
               cycle_busy_q <= reg_wdata_i[BIT_CYCLE_BUSY];
               read_cycle_q <= reg_wdata_i[BIT_READ_CYCLE];
            end
         end
      end
   end

   // Mode strap caught once after reset release and after each bus reset
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         single_user_q <= 1'b0;
         strap_taken_q <= 1'b0;
      end else if (clk_en_i) begin
         if (bus_rst_s)
            strap_taken_q <= 1'b0;
         else if (!strap_taken_q) begin
            single_user_q <= strap_sync_q[1];
            strap_taken_q <= 1'b1;
         end
      end
   end

   // ****************************************************
   // Request / ownership state machine
   // ****************************************************
   typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_OWN, ST_RELEASE} own_e;
   own_e own_q;
   own_e own_d;

   wire blocked = bus_rst_s || chip_reset_bit_q;

   // Request raised on demand, held until grant seen gone and cycle busy clear
   always_comb begin
      own_d = own_q;
      unique case (own_q)
         ST_IDLE:    if (port_want_q && !blocked) own_d = ST_REQ;
         ST_REQ:     if (grant_s) own_d = ST_OWN;
         ST_OWN:     if (!grant_s) own_d = cycle_busy_q ? ST_RELEASE : ST_IDLE;
         ST_RELEASE: if (!cycle_busy_q) own_d = ST_IDLE;
      endcase
      if (blocked)
         own_d = ST_IDLE;
   end

   // Same rising edge as the arbitrator, so no extra sync on the handshake
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i)
         own_q <= ST_IDLE;
      else if (clk_en_i)
         own_q <= own_d;
   end

   // ****************************************************
   // Pin drivers
   // ****************************************************
   // Single user: grant is tied low, so ownership follows the sampled grant
   wire single_drive = single_user_q && grant_s && !blocked && !read_cycle_q;
   wire multi_drive  = (own_q == ST_OWN) || (own_q == ST_RELEASE);
   wire owns_port    = single_user_q ? (grant_s && !blocked) : multi_drive;

   // Request stays low from first assertion until grant seen deasserted and cycle busy clear
   assign port_request_n_o    = !((own_q == ST_REQ) || multi_drive);
   assign port_request_n_oe_o = !blocked;
   assign port_drive_en_o     = single_user_q ? single_drive : (multi_drive && !blocked);
   assign port_stall_o        = port_want_q && !owns_port;

   // Strobes gated by live select bits and port ownership
   assign board_out_en_n_o        = !(board_read_select_q && serial_mem_select_q && owns_port);
   assign board_write_strobe_o    = !board_read_select_q && board_strobe_bit_q &&
                                    serial_mem_select_q && owns_port;
   assign board_out_en_n_oe_o     = !bus_rst_s;
   assign board_write_strobe_oe_o = !bus_rst_s;

   // ****************************************************
   // Read back
   // ****************************************************
   wire [7:0] board_rd = {md_sync2_q & {6{!board_out_en_n_o}}, board_strobe_bit_q, board_read_select_q};
   wire [7:0] ser_rd   = {grant_s, 6'h00, serial_mem_select_q};
   wire [7:0] cfg_rd   = {7'h00, single_user_q};
   wire [7:0] chip_rd  = {7'h00, chip_reset_bit_q};
   wire [7:0] port_rd  = {4'h0, owns_port, read_cycle_q, cycle_busy_q, port_want_q};

   wire [7:0] rd_mux = (reg_addr_i == OFS_BOARD_CTRL)    ? board_rd :
                       (reg_addr_i == OFS_SERIAL_MEM)    ? ser_rd   :
                       (reg_addr_i == OFS_DEVICE_CONFIG) ? cfg_rd   :
                       (reg_addr_i == OFS_CHIP_CTRL)     ? chip_rd  :
                       (reg_addr_i == OFS_PORT_CTRL)     ? port_rd  : RST_BYTE;

   // Read data valid only in the cycle after the strobe
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i)
         reg_rdata_o <= RST_BYTE;
      else if (clk_en_i)
         reg_rdata_o <= reg_rd_i ? rd_mux : RST_BYTE;
   end
endmodule

// ==== tb/port_share_monitor.sv ====
// Checker for the memory port share block, bound to its top module.
// Assumes one clock domain and pins that change away from the edge.
`timescale 1ns/1ps
module port_share_monitor
   import port_share_pkg::*;
(
   input wire logic              sys_clk_i,
   input wire logic              resetn_i,
   input wire logic [ADDR_W-1:0] reg_addr_i,
   input wire logic              reg_rd_i,
   input wire logic [7:0]        reg_rdata_o,
   input wire logic              host_bus_reset_n_i,
   input wire logic              port_grant_n_i,
   input wire logic              single_user_strap_i,
   input wire logic              port_request_n_o,
   input wire logic              port_request_n_oe_o,
   input wire logic              port_drive_en_o,
   input wire logic              board_out_en_n_o,
   input wire logic              board_out_en_n_oe_o,
   input wire logic              board_write_strobe_o,
   input wire logic              board_write_strobe_oe_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);
   // Three sampled edges of bus reset cover the two-flop sync
   chk_pins_float: assert property ((!host_bus_reset_n_i) [*3] |-> !board_out_en_n_oe_o && !port_drive_en_o
      && !board_write_strobe_oe_o && !port_request_n_oe_o) else $error("pins driven in bus reset");
   chk_strobes_apart: assert property (!(!board_out_en_n_o && board_write_strobe_o))
      else $error("board enable and strobe together");
   chk_oe_owner: assert property (!board_out_en_n_o && board_out_en_n_oe_o |-> !port_request_n_o || single_user_strap_i)
      else $error("board enable without ownership");
   chk_we_owner: assert property (board_write_strobe_o && board_write_strobe_oe_o |-> !port_request_n_o
      || single_user_strap_i) else $error("board strobe without ownership");
   chk_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
      else $error("read data outside its cycle");
   chk_grant_level: assert property (reg_rd_i && reg_addr_i == OFS_SERIAL_MEM && $stable(port_grant_n_i)
      && port_grant_n_i == $past(port_grant_n_i, 2) && port_grant_n_i == $past(port_grant_n_i, 3)
      |=> reg_rdata_o[BIT_GRANT_LEVEL] == !$past(port_grant_n_i)) else $error("grant level misread");
   chk_drive_grant: assert property ($rose(port_drive_en_o) |-> !$past(port_grant_n_i, 2))
      else $error("port driven without sampled grant");
   chk_drive_request: assert property (port_drive_en_o && !single_user_strap_i |-> !port_request_n_o
      && port_request_n_oe_o) else $error("multiuser drive without request");
   cov_drive: cover property ($rose(port_drive_en_o));
   cov_read: cover property (!board_out_en_n_o);
   cov_write: cover property (board_write_strobe_o);
endmodule
bind memory_port_share port_share_monitor port_share_monitor_i (.sys_clk_i, .resetn_i, .reg_addr_i, .reg_rd_i,
   .reg_rdata_o, .host_bus_reset_n_i, .port_grant_n_i, .single_user_strap_i, .port_request_n_o,
   .port_request_n_oe_o, .port_drive_en_o, .board_out_en_n_o, .board_out_en_n_oe_o, .board_write_strobe_o,
   .board_write_strobe_oe_o);

// ==== tb/arb_model.sv ====
// Arbitrator model with one rival user and a grant lag.
// Assumes a released request pin reads high.
`timescale 1ns/1ps
module arb_model (
   input  wire logic       clk_i,
   input  wire logic       resetn_i,
   input  wire logic       single_i,
   input  wire logic       rival_i,
   input  wire logic       req_n_i,
   input  wire logic [3:0] lag_i,
   output logic            grant_n_o
);
   logic       own_q, rival_q;
   logic [3:0] wait_q;
   // Strapped mode ties grant low
   assign grant_n_o = single_i ? 1'b0 : !own_q;
   // Rival waits for our request to drop; lag can wrap, so slow answers stay bounded
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         own_q   <= 1'b0;
         rival_q <= 1'b0;
         wait_q  <= 4'h0;
      end else begin
         own_q   <= own_q ? !rival_i : (!rival_q && !rival_i && !req_n_i && wait_q == lag_i);
         rival_q <= rival_q ? rival_i : (!own_q && rival_i && req_n_i);
         wait_q  <= (req_n_i || own_q) ? 4'h0 : wait_q + 4'h1;
      end
   end
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the memory port share block.
// Assumes the arbitrator model and bound checker are compiled first.
`timescale 1ns/1ps
module tb_top;
   import port_share_pkg::*;
   logic              sys_clk_i = 1'b0, resetn_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, rival = 1'b0;
   logic              host_bus_reset_n_i = 1'b1, single_user_strap_i = 1'b0, mem_data_parity_i = 1'b0;
   logic [ADDR_W-1:0] reg_addr_i = 4'h0;
   logic [7:0]        reg_wdata_i = 8'h00, reg_rdata_o;
   logic [4:0]        mem_data_upper_i = 5'h00;
   logic [3:0]        lag = 4'h0;
   logic [31:0]       rnd = 32'hA425C204;
   logic              port_grant_n_i, port_request_n_o, port_request_n_oe_o, port_drive_en_o, port_stall_o, req_n_w;
   logic              board_out_en_n_o, board_out_en_n_oe_o, board_write_strobe_o, board_write_strobe_oe_o;
   int                num_errors = 0, cmp_count = 0;
   // Released request pin floats to its inactive level
   assign req_n_w = port_request_n_oe_o ? port_request_n_o : 1'b1;
   memory_port_share memory_port_share_i (.sys_clk_i, .resetn_i, .clk_en_i(1'b1), .reg_addr_i, .reg_wdata_i,
      .reg_wr_i, .reg_rd_i, .reg_rdata_o, .host_bus_reset_n_i, .port_grant_n_i, .single_user_strap_i,
      .mem_data_upper_i, .mem_data_parity_i, .port_request_n_o, .port_request_n_oe_o, .port_drive_en_o,
      .board_out_en_n_o, .board_out_en_n_oe_o, .board_write_strobe_o, .board_write_strobe_oe_o, .port_stall_o);
   arb_model arb_model_i (.clk_i(sys_clk_i), .resetn_i, .single_i(single_user_strap_i), .rival_i(rival),
      .req_n_i(req_n_w), .lag_i(lag), .grant_n_o(port_grant_n_i));
   initial forever #4 sys_clk_i = ~sys_clk_i;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic close_out();
      $display("compares %0d errors %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) num_errors++;
      if (seen !== exp) $display("unexpected %s: expected %h seen %h", what, exp, seen);
   endtask
   // One register cycle; a read compares the data in the following cycle
   task automatic bus(input logic r, input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_rd_i    <= r;
      reg_wr_i    <= !r;
      @(posedge sys_clk_i);
      reg_rd_i    <= 1'b0;
      reg_wr_i    <= 1'b0;
      #1;
      if (r) check("rdata", reg_rdata_o, d);
   endtask
   // Bounded wait on port ownership
   task automatic wait_drive(input logic v);
      for (int n = 0; port_drive_en_o !== v; n++) begin
         if (n == 60) num_errors++;
         if (n == 60) close_out();
         @(posedge sys_clk_i);
         #1;
      end
   endtask
   // Pass 0 multiuser arbitration, pass 1 single-user followed by the board strobes
   initial begin
      for (int m = 0; m < 2; m++) begin
         single_user_strap_i <= m[0];
         resetn_i <= 1'b0;
         repeat (16) @(posedge sys_clk_i);
         resetn_i <= 1'b1;
         repeat (4) @(posedge sys_clk_i);
         bus(1'b1, OFS_DEVICE_CONFIG, {7'h00, m[0]});
         bus(1'b1, OFS_SERIAL_MEM, {m[0], 7'h00});
         bus(1'b1, 4'hF, 8'h00);
         for (int i = 0; i < 4 && m == 0; i++) begin
            rnd = lfsr(rnd);
            lag <= rnd[3:0];
            bus(1'b0, OFS_PORT_CTRL, {6'h00, rnd[4], 1'b1});
            check("stall", 8'(port_stall_o), 8'h01);
            check("drive", 8'(port_drive_en_o), 8'h00);
            wait_drive(1'b1);
            check("stall", 8'(port_stall_o), 8'h00);
            check("request", 8'(port_request_n_o), 8'h00);
            // Drop the demand first so losing the grant does not re-arm a request
            bus(1'b0, OFS_PORT_CTRL, {6'h00, rnd[4], 1'b0});
            rival <= 1'b1;
            repeat (6) @(posedge sys_clk_i);
            #1;
            check("drive", 8'(port_drive_en_o), {7'h00, rnd[4]});
            bus(1'b0, OFS_PORT_CTRL, 8'h00);
            wait_drive(1'b0);
            check("request", 8'(port_request_n_o), 8'h01);
            rival <= 1'b0;
         end
      end
      check("drive", 8'(port_drive_en_o), 8'h01);
      bus(1'b0, OFS_PORT_CTRL, 8'h04);
      check("drive", 8'(port_drive_en_o), 8'h00);
      bus(1'b0, OFS_SERIAL_MEM, 8'h01);
      for (int j = 0; j < 4; j++) begin
         rnd = lfsr(rnd);
         mem_data_upper_i  <= rnd[4:0];
         mem_data_parity_i <= rnd[5];
         bus(1'b0, OFS_BOARD_CTRL, 8'h01);
         check("board oe", 8'(board_out_en_n_o), 8'h00);
         bus(1'b1, OFS_BOARD_CTRL, {rnd[4:0], rnd[5], 2'b01});
      end
      bus(1'b0, OFS_BOARD_CTRL, 8'h02);
      check("strobe", 8'(board_write_strobe_o), 8'h01);
      bus(1'b1, OFS_BOARD_CTRL, 8'h02);
      bus(1'b0, OFS_SERIAL_MEM, 8'h00);
      check("strobe", 8'(board_write_strobe_o), 8'h00);
      bus(1'b0, OFS_CHIP_CTRL, 8'h01);
      check("request oe", 8'(port_request_n_oe_o), 8'h00);
      host_bus_reset_n_i <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
      #1;
      check("oe float", {board_out_en_n_oe_o, board_write_strobe_oe_o, port_drive_en_o}, 8'h00);
      close_out();
   end
endmodule
